/* File: core/indicator_pkg.sv */
// Constants, register map and carrier types for the indicator front-panel logic.
// Assumes a single 250 MHz system clock and an AHB-Lite register bus.
package indicator_pkg;
  localparam longint CLK_HZ = 250_000_000;
  localparam longint DEBOUNCE_MS = 10;
  localparam longint TIMEOUT_S = 25;
  localparam longint LOCK_HOLD_S = 3;
  localparam longint FLASH_MS = 500;
  localparam longint FREEZE_MSG_MS = 1000;
  localparam longint DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / 1000;
  localparam longint TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam longint LOCK_HOLD_CYC = LOCK_HOLD_S * CLK_HZ;
  localparam longint FLASH_CYC = FLASH_MS * CLK_HZ / 1000;
  localparam longint FREEZE_MSG_CYC = FREEZE_MSG_MS * CLK_HZ / 1000;

  localparam int KEY_PROG = 0;
  localparam int KEY_BACK = 1;
  localparam int KEY_UP = 2;
  localparam int KEY_DOWN = 3;
  localparam int KEY_FUNC = 4;
  localparam int KEY_CONTACT = 5;
  localparam int NUM_INPUTS = 6;

  localparam int NUM_CYCLES = 6;
  localparam logic [2:0] WORK_CYCLE = 3'h0;
  localparam logic [2:0] LAST_CYCLE = 3'h5;
  localparam logic [2:0] LAST_PARAM = 3'h3;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] RETX_LO_OFF = 8'h04;
  localparam logic [7:0] RETX_HI_OFF = 8'h08;
  localparam logic [7:0] MAX_OFF = 8'h0C;
  localparam logic [7:0] MIN_OFF = 8'h10;
  localparam logic [7:0] DISP_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [7:0] RETX_OUT_OFF = 8'h1C;

  localparam int CTRL_FKEY_POS = 0;
  localparam int CTRL_CONTACT_POS = 2;
  localparam int CTRL_LIVE_ZERO_POS = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] RETX_LO_RESET = 16'h0000;
  localparam logic [15:0] RETX_HI_RESET = 16'h03E8;

  localparam logic [15:0] RETX_FULL = 16'hFFFF;
  localparam logic [15:0] RETX_LIVE_ZERO = 16'h3333;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    FN_NONE,
    FN_FREEZE,
    FN_CLEAR,
    FN_PEAK
  } fn_action_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic edit_inc;
    logic edit_dec;
    logic nv_commit;
    logic [2:0] cycle;
    logic [2:0] param;
  } menu_out_t;
endpackage : indicator_pkg

/* File: core/indicator_panel.sv */
// Front-panel logic: extremes, special functions, menu, protection, retransmission.
// Assumes raw key/contact pins high while pressed/closed and a PV strobe on clk_sys.
// What this block does
// - Keep largest and smallest PV since clear; show them on max/min key.
// - Max and min keys held together in the work display clear both extremes to present value.
// - Freeze action toggles between frozen value and live reading per activation.
// - While frozen, periodically show a freeze message.
// - Peak-track shows maximum since last activation; activation restarts it.
// - Clear-extremes action clears both extremes on every activation.
// - Function key and contact each have their own action selection.
// - Retransmission maps PV linearly between low and high limits, inversion allowed.
// - Retransmission output is always driven, no enable.
// - A setting selects span start at zero or live zero, to full scale.
// - Menu is ordered cycles; work cycle free, others reserved.
// - Reserved cycles entered only with program plus back held together.
// - Program press advances parameter; past last returns to work cycle.
// - Back press returns to previous parameter in the cycle.
// - Up/down edit value; commit pulse when menu advances.
// - 25 s without keys in a menu returns to work cycle.
// - Holding lock pair 3 s locks cycle; unlock pair 3 s unlocks.
// - Locked cycle stays viewable but up/down edits are blocked.
// - Display flashes briefly after lock or unlock.
// - Active strap ignores lock and unlock sequences.
// - One lamp per active alarm, plus receive and transmit lamps.
`timescale 1ns/1ps
module indicator_panel
  import indicator_pkg::*;
#(
  parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter longint LOCK_HOLD_CYCLES = LOCK_HOLD_CYC,
  parameter longint FLASH_CYCLES = FLASH_CYC,
  parameter longint FREEZE_MSG_CYCLES = FREEZE_MSG_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire indicator_pkg::ahb_req_t ahb_req,
  output indicator_pkg::ahb_rsp_t ahb_rsp,
  input wire logic [5:0] raw_inputs,
  input wire logic unlock_guard_strap,
  input wire logic signed [15:0] pv_in,
  input wire logic pv_valid,
  input wire logic [3:0] alarm_active,
  input wire logic rx_active,
  input wire logic tx_active,
  output logic signed [15:0] display_value,
  output logic freeze_msg,
  output logic peak_track_mode,
  output logic display_blank,
  output indicator_pkg::menu_out_t menu_out,
  output logic [15:0] retx_code,
  output logic [3:0] alarm_lamps,
  output logic rx_lamp,
  output logic tx_lamp
);
  import indicator_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_MENU
  } menu_state_t;

  logic [5:0] db_reg;
  logic [5:0] db_d_reg;
  logic [5:0] press;
  logic [2:0] strap_sync_reg;
  logic strap_reg;

  // Three-stage sync, then a stability count before the debounced level moves
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_db
      logic [2:0] sync_reg;
      logic [31:0] cnt_reg;
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          sync_reg <= 3'h0;
          cnt_reg <= 32'h0;
          db_reg[gi] <= 1'b0;
        end
        else
        begin
          sync_reg <= {sync_reg[1:0], raw_inputs[gi]};
          if (sync_reg[2] != sync_reg[1] || sync_reg[2] == db_reg[gi])
            cnt_reg <= 32'h0;
          else if (cnt_reg >= 32'(DEBOUNCE_CYCLES - 1))
          begin
            cnt_reg <= 32'h0;
            db_reg[gi] <= sync_reg[2];
          end
          else
            cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      db_d_reg <= 6'h00;
      strap_sync_reg <= 3'h0;
      strap_reg <= 1'b0;
    end
    else
    begin
      db_d_reg <= db_reg;
      strap_sync_reg <= {strap_sync_reg[1:0], unlock_guard_strap};
      if (strap_sync_reg[2] == strap_sync_reg[1])
        strap_reg <= strap_sync_reg[2];
    end
  end

  function automatic logic both(input logic [5:0] v, input int a, input int b);
    return v[a] & v[b];
  endfunction : both

  assign press = db_reg & ~db_d_reg;
  wire solo = (db_reg[3:0] & (db_reg[3:0] - 4'h1)) == 4'h0;
  wire maxmin_pair = both(db_reg, KEY_UP, KEY_DOWN) & ~both(db_d_reg, KEY_UP, KEY_DOWN);
  wire enter_pair = both(db_reg, KEY_PROG, KEY_BACK) & ~both(db_d_reg, KEY_PROG, KEY_BACK);
  wire lock_pair = both(db_reg, KEY_BACK, KEY_UP) & ~db_reg[KEY_DOWN];
  wire unlock_pair = both(db_reg, KEY_BACK, KEY_DOWN) & ~db_reg[KEY_UP];

  // Registers
  logic [4:0] ctrl_reg;
  logic signed [15:0] retx_lo_reg;
  logic signed [15:0] retx_hi_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] rd_addr_reg;
  wire addr_phase = ahb_req.hsel & ahb_req.hready & (ahb_req.htrans == HTRANS_NONSEQ);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      ctrl_reg <= CTRL_RESET;
      retx_lo_reg <= RETX_LO_RESET;
      retx_hi_reg <= RETX_HI_RESET;
    end
    else
    begin
      wr_pend_reg <= addr_phase & ahb_req.hwrite;
      wr_addr_reg <= ahb_req.haddr[7:0];
      if (addr_phase & ~ahb_req.hwrite)
        rd_addr_reg <= ahb_req.haddr[7:0];
      if (wr_pend_reg)
      begin
        case (wr_addr_reg)
          CTRL_OFF: ctrl_reg <= ahb_req.hwdata[4:0];
          RETX_LO_OFF: retx_lo_reg <= ahb_req.hwdata[15:0];
          RETX_HI_OFF: retx_hi_reg <= ahb_req.hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Special functions
  logic signed [15:0] max_reg;
  logic signed [15:0] min_reg;
  logic signed [15:0] peak_reg;
  logic signed [15:0] frozen_reg;
  logic freeze_reg;
  logic peak_reg_on;
  logic [31:0] msg_cnt_reg;
  fn_action_t act;
  wire fn_fkey = press[KEY_FUNC];
  wire fn_contact = press[KEY_CONTACT];

  always_comb
  begin
    act = FN_NONE;
    if (fn_fkey)
      act = fn_action_t'(ctrl_reg[CTRL_FKEY_POS +: 2]);
    else if (fn_contact)
      act = fn_action_t'(ctrl_reg[CTRL_CONTACT_POS +: 2]);
  end

  wire in_work = (menu_out.cycle == WORK_CYCLE) && (menu_out.param == 3'h0);
  wire clr_ext = (maxmin_pair & in_work) | (act == FN_CLEAR);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      max_reg <= 16'h0000;
      min_reg <= 16'h0000;
    end
    else if (clr_ext)
    begin
      max_reg <= pv_in;
      min_reg <= pv_in;
    end
    else if (pv_valid)
    begin
      if (pv_in > max_reg)
        max_reg <= pv_in;
      if (pv_in < min_reg)
        min_reg <= pv_in;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      freeze_reg <= 1'b0;
      frozen_reg <= 16'h0000;
      peak_reg_on <= 1'b0;
      peak_reg <= 16'h0000;
    end
    else
    begin
      if (act == FN_FREEZE)
      begin
        freeze_reg <= ~freeze_reg;
        frozen_reg <= pv_in;
      end
      if (act == FN_PEAK)
      begin
        peak_reg_on <= 1'b1;
        peak_reg <= pv_in;
      end
      else if (pv_valid && pv_in > peak_reg)
        peak_reg <= pv_in;
      // Peak display ends once neither source is set to peak track
      if (ctrl_reg[CTRL_FKEY_POS +: 2] != 2'(FN_PEAK) && ctrl_reg[CTRL_CONTACT_POS +: 2] != 2'(FN_PEAK))
        peak_reg_on <= 1'b0;
    end
  end

  // Message blinks on for half of each period while frozen
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      msg_cnt_reg <= 32'h0;
    else if (!freeze_reg || msg_cnt_reg >= 32'(FREEZE_MSG_CYCLES - 1))
      msg_cnt_reg <= 32'h0;
    else
      msg_cnt_reg <= msg_cnt_reg + 32'h1;
  end

  // Menu navigation
  menu_state_t state_reg;
  logic [5:0] lock_reg;
  logic [33:0] idle_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic hold_done_reg;
  logic [31:0] flash_cnt_reg;
  wire any_key = |press[3:0];
  wire timeout = (state_reg == ST_MENU) && (idle_cnt_reg >= 34'(TIMEOUT_CYCLES - 1));
  wire cur_locked = lock_reg[menu_out.cycle];
  wire pair_held = (lock_pair | unlock_pair) & (state_reg == ST_MENU) & ~strap_reg;
  wire hold_fire = pair_held & ~hold_done_reg & (hold_cnt_reg >= 32'(LOCK_HOLD_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      menu_out <= '0;
    end
    else
    begin
      menu_out.edit_inc <= 1'b0;
      menu_out.edit_dec <= 1'b0;
      menu_out.nv_commit <= 1'b0;
      if (timeout)
      begin
        state_reg <= ST_IDLE;
        menu_out.cycle <= WORK_CYCLE;
        menu_out.param <= 3'h0;
      end
      else if (enter_pair)
      begin
        state_reg <= ST_MENU;
        menu_out.cycle <= (menu_out.cycle == LAST_CYCLE) ? 3'h1 : menu_out.cycle + 3'h1;
        menu_out.param <= 3'h0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (press[KEY_PROG] & solo)
            begin
              state_reg <= ST_MENU;
              menu_out.param <= 3'h1;
            end
          end
          ST_MENU:
          begin
            if (press[KEY_PROG] & solo)
            begin
              menu_out.nv_commit <= 1'b1;
              if (menu_out.param == LAST_PARAM)
              begin
                state_reg <= ST_IDLE;
                menu_out.cycle <= WORK_CYCLE;
                menu_out.param <= 3'h0;
              end
              else
                menu_out.param <= menu_out.param + 3'h1;
            end
            else if (press[KEY_BACK] & solo && menu_out.param != 3'h0)
              menu_out.param <= menu_out.param - 3'h1;
            else if (~cur_locked & solo)
            begin
              menu_out.edit_inc <= press[KEY_UP];
              menu_out.edit_dec <= press[KEY_DOWN];
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      idle_cnt_reg <= 34'h0;
    else if (any_key || state_reg == ST_IDLE || timeout)
      idle_cnt_reg <= 34'h0;
    else
      idle_cnt_reg <= idle_cnt_reg + 34'h1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hold_cnt_reg <= 32'h0;
      hold_done_reg <= 1'b0;
      lock_reg <= 6'h00;
    end
    else if (!pair_held)
    begin
      hold_cnt_reg <= 32'h0;
      hold_done_reg <= 1'b0;
    end
    else if (hold_fire)
    begin
      hold_done_reg <= 1'b1;
      lock_reg[menu_out.cycle] <= lock_pair;
    end
    else if (!hold_done_reg)
      hold_cnt_reg <= hold_cnt_reg + 32'h1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flash_cnt_reg <= 32'h0;
    else if (hold_fire)
      flash_cnt_reg <= 32'(FLASH_CYCLES);
    else if (flash_cnt_reg != 32'h0)
      flash_cnt_reg <= flash_cnt_reg - 32'h1;
  end

  // Retransmission; inverted limits give a negative den and so a falling output
  logic [15:0] base;
  logic signed [17:0] num;
  logic signed [17:0] den;
  logic signed [39:0] quot;
  logic signed [17:0] span;
  logic [15:0] code;

  always_comb
  begin
    base = ctrl_reg[CTRL_LIVE_ZERO_POS] ? RETX_LIVE_ZERO : 16'h0000;
    num = 18'(pv_in) - 18'(retx_lo_reg);
    den = 18'(retx_hi_reg) - 18'(retx_lo_reg);
    // Signed throughout: one unsigned operand would wreck the inverted slope
    span = 18'(RETX_FULL - base);
    quot = 40'h0;
    if (den != 18'h0)
      quot = (40'(num) * 40'(span)) / 40'(den);
    if (quot < 40'sh0)
      code = base;
    else if (quot > 40'(span))
      code = RETX_FULL;
    else
      code = base + quot[15:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      retx_code <= RETX_LIVE_ZERO;
      display_value <= 16'h0000;
      freeze_msg <= 1'b0;
      peak_track_mode <= 1'b0;
      display_blank <= 1'b0;
      alarm_lamps <= 4'h0;
      rx_lamp <= 1'b0;
      tx_lamp <= 1'b0;
    end
    else
    begin
      retx_code <= code;
      freeze_msg <= freeze_reg && (msg_cnt_reg < 32'(FREEZE_MSG_CYCLES / 2));
      peak_track_mode <= peak_reg_on & ~freeze_reg;
      display_blank <= flash_cnt_reg[4];
      alarm_lamps <= alarm_active;
      rx_lamp <= rx_active;
      tx_lamp <= tx_active;
      if (in_work & db_reg[KEY_UP] & ~db_reg[KEY_DOWN])
        display_value <= max_reg;
      else if (in_work & db_reg[KEY_DOWN] & ~db_reg[KEY_UP])
        display_value <= min_reg;
      else if (freeze_reg)
        display_value <= frozen_reg;
      else if (peak_reg_on)
        display_value <= peak_reg;
      else
        display_value <= pv_in;
    end
  end

  // Bus read side; slave never stalls
  always_comb
  begin
    ahb_rsp.hreadyout = 1'b1;
    ahb_rsp.hresp = 1'b0;
    case (rd_addr_reg)
      CTRL_OFF: ahb_rsp.hrdata = {27'h0, ctrl_reg};
      RETX_LO_OFF: ahb_rsp.hrdata = {16'h0, retx_lo_reg};
      RETX_HI_OFF: ahb_rsp.hrdata = {16'h0, retx_hi_reg};
      MAX_OFF: ahb_rsp.hrdata = {16'h0, max_reg};
      MIN_OFF: ahb_rsp.hrdata = {16'h0, min_reg};
      DISP_OFF: ahb_rsp.hrdata = {16'h0, display_value};
      STATUS_OFF: ahb_rsp.hrdata = {15'h0, strap_reg, lock_reg, 1'b0, menu_out.param, 1'b0, menu_out.cycle,
                                    peak_reg_on, freeze_reg};
      RETX_OUT_OFF: ahb_rsp.hrdata = {16'h0, retx_code};
      default: ahb_rsp.hrdata = 32'h0;
    endcase
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_clear_pair; maxmin_pair & in_work |=> max_reg == $past(pv_in) && min_reg == $past(pv_in); endproperty
  a_clear_pair: assert property (p_clear_pair) else $error("extremes not cleared");
  property p_max_order; pv_valid & ~clr_ext |=> max_reg >= min_reg || $past(max_reg < min_reg); endproperty
  a_max_order: assert property (p_max_order) else $error("max below min");
  property p_freeze; act == FN_FREEZE |=> freeze_reg != $past(freeze_reg) ##1 (!$past(freeze_reg)
    || display_value == $past(frozen_reg) || $past(in_work) && $past(db_reg[KEY_UP]) != $past(db_reg[KEY_DOWN]));
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not toggled");
  property p_peak; act == FN_PEAK |=> peak_reg == $past(pv_in) && peak_reg_on; endproperty
  a_peak: assert property (p_peak) else $error("peak not restarted");
  property p_no_msg; !freeze_reg |=> !freeze_msg; endproperty
  a_no_msg: assert property (p_no_msg) else $error("freeze message while live");
  sequence s_timeout; timeout; endsequence
  sequence s_home; state_reg == ST_IDLE && menu_out.cycle == WORK_CYCLE; endsequence
  property p_timeout; s_timeout |=> s_home; endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not return");
  property p_locked; cur_locked & state_reg == ST_MENU & ~enter_pair |=> !menu_out.edit_inc && !menu_out.edit_dec;
  endproperty
  a_locked: assert property (p_locked) else $error("edit in locked cycle");
  property p_strap; strap_reg |=> $stable(lock_reg); endproperty
  a_strap: assert property (p_strap) else $error("lock changed under strap");
  property p_flash; hold_fire |=> flash_cnt_reg == 32'(FLASH_CYCLES); endproperty
  a_flash: assert property (p_flash) else $error("no flash after lock");
  property p_commit; state_reg == ST_MENU && press[KEY_PROG] && solo && !timeout && !enter_pair |=> menu_out.nv_commit;
  endproperty
  a_commit: assert property (p_commit) else $error("no commit on advance");
endmodule : indicator_panel

/* File: testbench/keypad_contact_model.sv */
// Partner model: operator keypad and dry contact, with chatter on every change.
// Assumes key_req is driven by the bench right after clk_sys edges.
`timescale 1ns/1ps
module keypad_contact_model
(
  input wire logic clk_sys,
  input wire logic [5:0] key_req,
  output logic [5:0] raw_pins
);
  logic [5:0] req_d = 6'h00;
  logic [5:0] bounce_mask = 6'h00;
  logic [2:0] bounce_cnt = 3'h0;

  // Real switches chatter; a few flips per change make the debouncer earn its keep
  always @(posedge clk_sys)
  begin
    req_d <= key_req;
    if (key_req != req_d)
    begin
      bounce_mask <= key_req ^ req_d;
      bounce_cnt <= 3'h5;
    end
    else if (bounce_cnt != 3'h0)
    begin
      bounce_cnt <= bounce_cnt - 3'h1;
    end
  end

  // Closed contact reads high, open reads low
  assign raw_pins = key_req ^ (bounce_cnt[0] ? bounce_mask : 6'h00);
endmodule : keypad_contact_model

/* File: testbench/indicator_keypad_special_functions_tb_top.sv */
// Self-checking bench: bus tasks, key presses through the keypad model, PV samples.
// Assumes shortened timing parameters; hreadyout feeds back as the bus hready.
`timescale 1ns/1ps
module indicator_keypad_special_functions_tb_top;
  import indicator_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ahb_req_t req_q;
  ahb_req_t bus;
  ahb_rsp_t ahb_rsp;
  logic [5:0] key_req;
  logic [5:0] raw_pins;
  logic strap;
  logic signed [15:0] pv_in;
  logic pv_valid;
  logic [3:0] alarm_active;
  logic rx_active;
  logic tx_active;
  logic signed [15:0] display_value;
  logic freeze_msg;
  logic peak_track_mode;
  logic display_blank;
  menu_out_t menu_out;
  logic [15:0] retx_code;
  logic [3:0] alarm_lamps;
  logic rx_lamp;
  logic tx_lamp;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;
  int edit_cnt = 0;
  int commit_cnt = 0;
  int msg_cnt = 0;
  int blank_cnt = 0;

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  always_comb
  begin
    bus = req_q;
    bus.hready = ahb_rsp.hreadyout;
  end

  // Edit and commit pulses last one cycle, so they are counted rather than polled
  always @(posedge clk_sys)
  begin
    if (menu_out.edit_inc === 1'b1 || menu_out.edit_dec === 1'b1) edit_cnt++;
    if (menu_out.nv_commit === 1'b1) commit_cnt++;
    if (freeze_msg === 1'b1) msg_cnt++;
    if (display_blank === 1'b1) blank_cnt++;
  end

  keypad_contact_model keys (.clk_sys(clk_sys), .key_req(key_req), .raw_pins(raw_pins));

  indicator_panel #(
    .DEBOUNCE_CYCLES(4),
    .TIMEOUT_CYCLES(200),
    .LOCK_HOLD_CYCLES(50),
    .FLASH_CYCLES(64),
    .FREEZE_MSG_CYCLES(20)
  ) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .ahb_req(bus),
    .ahb_rsp(ahb_rsp),
    .raw_inputs(raw_pins),
    .unlock_guard_strap(strap),
    .pv_in(pv_in),
    .pv_valid(pv_valid),
    .alarm_active(alarm_active),
    .rx_active(rx_active),
    .tx_active(tx_active),
    .display_value(display_value),
    .freeze_msg(freeze_msg),
    .peak_track_mode(peak_track_mode),
    .display_blank(display_blank),
    .menu_out(menu_out),
    .retx_code(retx_code),
    .alarm_lamps(alarm_lamps),
    .rx_lamp(rx_lamp),
    .tx_lamp(tx_lamp)
  );

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ahb_rsp.hreadyout !== 1'b1 && n < 32);
    if (ahb_rsp.hreadyout !== 1'b1)
    begin
      fail_count++;
      conclude();
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req_q.hsel <= 1'b1;
    req_q.haddr <= {24'h000000, a};
    req_q.htrans <= HTRANS_NONSEQ;
    req_q.hwrite <= wr;
    req_q.hsize <= 3'h2;
    wait_rdy();
    req_q.htrans <= 2'h0;
    req_q.hwdata <= wd;
    wait_rdy();
    rd = ahb_rsp.hrdata;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  task automatic press(input logic [5:0] mask, input int hold);
    key_req <= mask;
    repeat (hold) @(posedge clk_sys);
    key_req <= 6'h00;
    repeat (24) @(posedge clk_sys);
  endtask : press

  task automatic hold_show(input logic [5:0] mask, input logic [31:0] exp);
    key_req <= mask;
    repeat (20) @(posedge clk_sys);
    check(display_value, exp);
    key_req <= 6'h00;
    repeat (24) @(posedge clk_sys);
  endtask : hold_show

  task automatic sample(input logic signed [15:0] v);
    pv_in <= v;
    pv_valid <= 1'b1;
    @(posedge clk_sys);
    pv_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : sample

  task automatic retx(input logic signed [15:0] v, input logic [15:0] exp);
    sample(v);
    repeat (4) @(posedge clk_sys);
    check({16'h0000, retx_code}, {16'h0000, exp});
  endtask : retx

  initial
  begin
    req_q = '0;
    key_req = 6'h00;
    strap = 1'b0;
    pv_in = 16'sh0000;
    pv_valid = 1'b0;
    alarm_active = 4'h0;
    rx_active = 1'b0;
    tx_active = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk(CTRL_OFF, 32'h0);
    rchk(RETX_LO_OFF, 32'h0);
    rchk(RETX_HI_OFF, 32'h3E8);
    rchk(8'h40, 32'h0);
    sample(100);
    sample(300);
    sample(-20);
    rchk(MAX_OFF, 32'h12C);
    rchk(MIN_OFF, 32'hFFEC);
    hold_show(6'h04, 32'h12C);
    hold_show(6'h08, 32'hFFFFFFEC);
    press(6'h0C, 20);
    rchk(MAX_OFF, 32'hFFEC);
    rchk(MIN_OFF, 32'hFFEC);
    sample(60);
    rchk(MAX_OFF, 32'h3C);
    // Freeze on the function key; a long hold must toggle only once
    xfer(1'b1, CTRL_OFF, 32'h1);
    sample(40);
    press(6'h10, 60);
    sample(77);
    xfer(1'b0, STATUS_OFF, 32'h0);
    check(rd[0], 1'b1);
    check(display_value, 32'd40);
    msg_cnt = 0;
    repeat (60) @(posedge clk_sys);
    check(msg_cnt != 0, 1'b1);
    press(6'h10, 20);
    sample(78);
    xfer(1'b0, STATUS_OFF, 32'h0);
    check(rd[0], 1'b0);
    check(display_value, 32'd78);
    msg_cnt = 0;
    repeat (40) @(posedge clk_sys);
    check(msg_cnt, 0);
    // Contact clears extremes while the key is set to no action
    xfer(1'b1, CTRL_OFF, 32'h8);
    sample(500);
    sample(10);
    press(6'h10, 20);
    rchk(MAX_OFF, 32'h1F4);
    press(6'h20, 20);
    rchk(MAX_OFF, 32'hA);
    rchk(MIN_OFF, 32'hA);
    xfer(1'b1, CTRL_OFF, 32'hC);
    sample(5);
    press(6'h20, 20);
    sample(90);
    sample(30);
    check(display_value, 32'd90);
    check(peak_track_mode, 1'b1);
    press(6'h20, 20);
    sample(20);
    check(display_value, 32'd30);
    // Span ends, live zero and inverted limits
    xfer(1'b1, CTRL_OFF, 32'h0);
    retx(0, 16'h0000);
    check(peak_track_mode, 1'b0);
    retx(1000, 16'hFFFF);
    xfer(1'b1, CTRL_OFF, 32'h10);
    retx(0, RETX_LIVE_ZERO);
    xfer(1'b1, RETX_LO_OFF, 32'd1000);
    xfer(1'b1, RETX_HI_OFF, 32'h0);
    retx(0, 16'hFFFF);
    retx(1000, RETX_LIVE_ZERO);
    rchk(RETX_OUT_OFF, 32'h3333);
    alarm_active <= 4'h5;
    rx_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(alarm_lamps, 4'h5);
    check({rx_lamp, tx_lamp}, 2'h2);
    rx_active <= 1'b0;
    tx_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({rx_lamp, tx_lamp}, 2'h1);
    // Menu navigation, reserved entry, lock, strap and timeout
    commit_cnt = 0;
    press(6'h01, 20);
    check(menu_out.param, 3'h1);
    check(commit_cnt, 0);
    press(6'h02, 20);
    check({menu_out.cycle, menu_out.param}, 6'h00);
    repeat (4) press(6'h01, 20);
    check({menu_out.cycle, menu_out.param}, 6'h00);
    check(commit_cnt, 4);
    press(6'h03, 20);
    check({menu_out.cycle, menu_out.param}, 6'h08);
    edit_cnt = 0;
    press(6'h04, 20);
    check(edit_cnt, 1);
    blank_cnt = 0;
    press(6'h06, 80);
    xfer(1'b0, STATUS_OFF, 32'h0);
    check(rd[11], 1'b1);
    check(blank_cnt != 0, 1'b1);
    press(6'h04, 20);
    press(6'h08, 20);
    check(edit_cnt, 1);
    press(6'h01, 20);
    check(menu_out.param, 3'h1);
    press(6'h0A, 80);
    xfer(1'b0, STATUS_OFF, 32'h0);
    check(rd[11], 1'b0);
    press(6'h08, 20);
    check(edit_cnt, 2);
    strap <= 1'b1;
    press(6'h06, 80);
    xfer(1'b0, STATUS_OFF, 32'h0);
    check(rd[11], 1'b0);
    strap <= 1'b0;
    repeat (260) @(posedge clk_sys);
    check({menu_out.cycle, menu_out.param}, 6'h00);
    conclude();
  end
endmodule : indicator_keypad_special_functions_tb_top
